// ### verification/sdirx_regs_chk.sv
// Port checker of the receiver register group.
// Assumes binding to sdirx_regs with one clock, async reset.
module sdirx_regs_chk (
  input logic clk,
  input logic rst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [10:0] faultsStreamOne,
  input logic [6:0] faultsStreamTwo,
  input logic [10:0] globalErrorStreamOne,
  input logic [6:0] globalErrorStreamTwo,
  input logic ddrClockPhaseSelect,
  input logic [4:0] delayTapOffset,
  input logic equalizerSkip,
  input logic lockNoiseImmunityEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Masked vector never shows a fault that was absent
  err_one_mask_a: assert property ((globalErrorStreamOne &
    ~$past(faultsStreamOne)) == 11'h000) else $error("stream one leak");
  rsvd_bit_zero_a: assert property (
    globalErrorStreamOne[7] == 1'h0) else $error("reserved bit set");
  err_two_mask_a: assert property ((globalErrorStreamTwo &
    ~$past(faultsStreamTwo)) == 7'h00) else $error("stream two leak");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write answer");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("bad read answer");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  // Controls may only move on the edge that applies a write
  clk_ctl_a: assert property ($changed({ddrClockPhaseSelect,
    delayTapOffset}) |-> $rose(s_axi_bvalid)) else $error("clk ctl moved");
  lock_ctl_a: assert property ($changed({lockNoiseImmunityEnable,
    equalizerSkip}) |-> $rose(s_axi_bvalid)) else $error("ctl moved");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (globalErrorStreamOne != 11'h000);
endmodule // sdirx_regs_chk

bind sdirx_regs sdirx_regs_chk u_sdirx_regs_chk (.*);

// ### verification/sdirx_regs_tb.sv
// Self-checking bench of the receiver register group.
// Assumes the design and its checker are compiled before it.
module sdirx_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ancWrEn = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic [10:0] faultsStreamOne = '0;
  logic [6:0] faultsStreamTwo = '0;
  logic [9:0] ancWrAddr = '0;
  logic [7:0] ancWrUpperWord = '0, ancWrLowerWord = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, ddrClockPhaseSelect, equalizerSkip, irq;
  wire lockNoiseImmunityEnable, rateDetectAutomatic;
  wire [1:0] s_axi_bresp, s_axi_rresp, manualRateSelect;
  wire [1:0] padDriveDataUpper, padDriveStatus, padDriveDataLower;
  wire [31:0] s_axi_rdata;
  wire [10:0] globalErrorStreamOne;
  wire [6:0] globalErrorStreamTwo;
  wire [4:0] delayTapOffset;
  int failures = 0, totalChecks = 0, cycles = 0;
  sdirx_regs u_sdirx_regs (.*);
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (failures == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Handshakes judged at the rising edge; each channel drops on its own
  task automatic wr(input [13:0] i, input [15:0] d, input [1:0] er);
    logic awDone, wDone;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    awDone = 1'h0;
    wDone = 1'h0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && s_axi_awready === 1'h1) begin
        awDone = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wDone && s_axi_wready === 1'h1) begin
        wDone = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input [13:0] i, input [31:0] ed, input [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic anc(input [9:0] a, input [7:0] u, l);
    @(posedge clk);
    ancWrEn <= 1'h1;
    ancWrAddr <= a;
    ancWrUpperWord <= u;
    ancWrLowerWord <= l;
    @(posedge clk) ancWrEn <= 1'h0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(14'h0037, 32'h0, 2'h0);
    rd(14'h0038, 32'h0, 2'h0);
    rd(14'h006C, 32'h0, 2'h0);
    rd(14'h006D, 32'h2B, 2'h0);
    rd(14'h0085, 32'h0, 2'h0);
    rd(14'h0024, 32'h4, 2'h0);
  endtask
  task automatic t_masks;
    wr(14'h0037, 16'hFFFF, 2'h0);
    rd(14'h0037, 32'h77F, 2'h0);
    wr(14'h0038, 16'hFFFF, 2'h0);
    rd(14'h0038, 32'h7F, 2'h0);
    wr(14'h0037, 16'h0001, 2'h0);
    wr(14'h0038, 16'h000F, 2'h0);
    @(posedge clk) faultsStreamOne <= 11'h7FF;
    faultsStreamTwo <= 7'h7F;
    repeat (2) @(posedge clk);
    @(negedge clk) chk("glob1", 11'h77E, globalErrorStreamOne);
    chk("glob2", 7'h70, globalErrorStreamTwo);
    @(posedge clk) faultsStreamOne <= 11'h000;
    faultsStreamTwo <= 7'h00;
    rd(14'h00F0, 32'h3, 2'h0);
    wr(14'h00F1, 16'h0007, 2'h0);
    rd(14'h00F0, 32'h0, 2'h0);
  endtask
  task automatic t_ctl;
    wr(14'h006C, 16'h003F, 2'h0);
    chk("phase", 1'h1, ddrClockPhaseSelect);
    chk("delay", 5'h1F, delayTapOffset);
    wr(14'h006C, 16'h0001, 2'h0);
    chk("phase0", {1'h0, 5'h01},
      {ddrClockPhaseSelect, delayTapOffset});
    wr(14'h006D, 16'h0016, 2'h0);
    chk("pad", 6'h16, {padDriveDataUpper, padDriveStatus, padDriveDataLower});
    wr(14'h0073, 16'h0200, 2'h0);
    chk("eq", 1'h1, equalizerSkip);
    wr(14'h0085, 16'h0400, 2'h0);
    chk("lock", 1'h1, lockNoiseImmunityEnable);
    wr(14'h0085, 16'h0000, 2'h0);
    wr(14'h0024, 16'h0002, 2'h0);
    chk("rate", 3'h2, {rateDetectAutomatic, manualRateSelect});
    wr(14'h0024, 16'h0004, 2'h0);
  endtask
  task automatic t_anc;
    anc(10'h000, 8'hA5, 8'h3C);
    anc(10'h3FF, 8'h5A, 8'hC3);
    rd(14'h0800, 32'hA53C, 2'h0);
    rd(14'h0BFF, 32'h5AC3, 2'h0);
    wr(14'h0800, 16'h1234, 2'h0);
    rd(14'h0800, 32'hA53C, 2'h0);
    // Earlier bank fills left bit 2 set; clear it so the pulse matters
    wr(14'h00F1, 16'h0004, 2'h0);
    wr(14'h00F2, 16'h0004, 2'h0);
    chk("irqidle", 1'h0, irq);
    anc(10'h001, 8'h11, 8'h22);
    chk("irq", 1'h1, irq);
    wr(14'h00F1, 16'h0004, 2'h0);
    chk("irqclr", 1'h0, irq);
    wr(14'h00F2, 16'h0000, 2'h0);
    anc(10'h002, 8'h33, 8'h44);
    chk("irqmask", 1'h0, irq);
    rd(14'h00F0, 32'h4, 2'h0);
    rd(14'h0100, 32'h0, 2'h2);
    wr(14'h0100, 16'hFFFF, 2'h2);
    rd(14'h00F1, 32'h0, 2'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_masks;
    t_ctl;
    t_anc;
    report_and_stop;
  end
endmodule // sdirx_regs_tb

// ### verilog/sdirx_consts.vh
// Constants of the receiver host register group.
// Assumes inclusion by bare name from the register module.
`ifndef SDIRX_CONSTS_VH
`define SDIRX_CONSTS_VH

// Register indexes; byte address is four times the index
`define SDIRX_IDX_MASK_ONE 14'h0037
`define SDIRX_IDX_MASK_TWO 14'h0038
`define SDIRX_IDX_RATE_SEL 14'h0024
`define SDIRX_IDX_CLK_DELAY 14'h006C
`define SDIRX_IDX_PAD_DRIVE 14'h006D
`define SDIRX_IDX_EQ_SKIP 14'h0073
`define SDIRX_IDX_LOCK_NOISE 14'h0085
`define SDIRX_IDX_IRQ_STATUS 14'h00F0
`define SDIRX_IDX_IRQ_CLEAR 14'h00F1
`define SDIRX_IDX_IRQ_ENABLE 14'h00F2
`define SDIRX_IDX_ANC_FIRST 14'h0800
`define SDIRX_IDX_ANC_LAST 14'h0BFF

// Writable bit sets
`define SDIRX_MASK_ONE_BITS 16'h077F
`define SDIRX_MASK_TWO_BITS 16'h007F

// Field positions
`define SDIRX_RATE_AUTO_BIT 2
`define SDIRX_CLK_PHASE_BIT 5
`define SDIRX_DELAY_MSB 4
`define SDIRX_EQ_SKIP_BIT 9
`define SDIRX_LOCK_NOISE_BIT 10
`define SDIRX_PAD_MSB_HI 5
`define SDIRX_PAD_STAT_HI 3
`define SDIRX_PAD_LSB_HI 1

// Reset values
`define SDIRX_RST_MASK 16'h0000
`define SDIRX_RST_RATE_AUTO 1'h1
`define SDIRX_RST_RATE_MAN 2'h0
`define SDIRX_RST_CLK_DELAY 6'h00
`define SDIRX_RST_PAD_DRIVE 6'h2B
`define SDIRX_RST_FLAG 1'h0
`define SDIRX_RST_IRQ 3'h0

// Interrupt status layout
`define SDIRX_IRQ_ERR_ONE 0
`define SDIRX_IRQ_ERR_TWO 1
`define SDIRX_IRQ_ANC 2

// AXI responses
`define SDIRX_RESP_OKAY 2'h0
`define SDIRX_RESP_SLVERR 2'h2

`endif

// ### verilog/sdirx_regs.v
// Host register group of the serial video receiver, AXI4-Lite slave.
// Assumes fault flags and ancillary writes come from logic on clk.
//
// Overview of operation
// RULE1: Stream one mask bits 10..0, bit 7 reserved.
// RULE2: Stream two mask bits 6..0 for second stream.
// RULE3: Set mask bit blocks fault from global vector.
// RULE4: Bit 5 picks quadrature clock for DDR.
// RULE5: Bits 4..0 set delay line offset.
// RULE6: Bit 10 enables three-TRS lock noise immunity.
// RULE7: Host enables noise immunity only under automatic rate.
// RULE8: Bit 2 automatic rate when set, resets set.
// RULE9: Ancillary bank 800h..BFFh read only from host.
// RULE10: Each location: upper word 15..8, lower 7..0.
`include "sdirx_consts.vh"

module sdirx_regs (
  input wire clk,
  input wire rst,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [10:0] faultsStreamOne,
  input wire [6:0] faultsStreamTwo,
  input wire ancWrEn,
  input wire [9:0] ancWrAddr,
  input wire [7:0] ancWrUpperWord,
  input wire [7:0] ancWrLowerWord,
  output reg [10:0] globalErrorStreamOne,
  output reg [6:0] globalErrorStreamTwo,
  output wire ddrClockPhaseSelect,
  output wire [4:0] delayTapOffset,
  output wire [1:0] padDriveDataUpper,
  output wire [1:0] padDriveStatus,
  output wire [1:0] padDriveDataLower,
  output wire equalizerSkip,
  output wire lockNoiseImmunityEnable,
  output wire rateDetectAutomatic,
  output wire [1:0] manualRateSelect,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  reg [15:0] maskOne_ff;
  reg [15:0] maskTwo_ff;
  reg rateAuto_ff;
  reg [1:0] rateMan_ff;
  reg [5:0] clkDelay_ff;
  reg [5:0] padDrive_ff;
  reg eqSkip_ff;
  reg lockNoise_ff;
  reg [2:0] irqStatus_ff;
  reg [2:0] irqEnable_ff;
  reg [15:0] ancMem [0:1023];

  reg awHeld_ff;
  reg [13:0] awIdx_ff;
  reg wHeld_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;

  // Merge written bytes into a 16-bit register image
  function [15:0] mergeBytes;
    input [15:0] oldVal;
    input [31:0] newVal;
    input [3:0] strb;
    begin
      mergeBytes[7:0] = strb[0] ? newVal[7:0] : oldVal[7:0];
      mergeBytes[15:8] = strb[1] ? newVal[15:8] : oldVal[15:8];
    end
  endfunction

  // Index falls inside the ancillary bank
  function inAncBank;
    input [13:0] idx;
    begin
      inAncBank = (idx >= `SDIRX_IDX_ANC_FIRST) &&
        (idx <= `SDIRX_IDX_ANC_LAST);
    end
  endfunction

  // Index names a register of this group
  function isMapped;
    input [13:0] idx;
    begin
      case (idx)
        `SDIRX_IDX_MASK_ONE, `SDIRX_IDX_MASK_TWO, `SDIRX_IDX_RATE_SEL,
        `SDIRX_IDX_CLK_DELAY, `SDIRX_IDX_PAD_DRIVE, `SDIRX_IDX_EQ_SKIP,
        `SDIRX_IDX_LOCK_NOISE, `SDIRX_IDX_IRQ_STATUS,
        `SDIRX_IDX_IRQ_CLEAR, `SDIRX_IDX_IRQ_ENABLE: isMapped = 1'b1;
        default: isMapped = inAncBank(idx);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write channels, taken in either order
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;

  wire doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  wire [15:0] wImage = wData_ff[15:0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awIdx_ff <= 14'h0000;
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDIRX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awIdx_ff <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awIdx_ff) ? `SDIRX_RESP_OKAY :
          `SDIRX_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  wire [15:0] nxt_maskOne = mergeBytes(maskOne_ff, wData_ff, wStrb_ff);
  wire [15:0] nxt_maskTwo = mergeBytes(maskTwo_ff, wData_ff, wStrb_ff);
  wire [15:0] rateImage = {13'h0000, rateAuto_ff, rateMan_ff};
  wire [15:0] nxt_rate = mergeBytes(rateImage, wData_ff, wStrb_ff);
  wire [15:0] eqImage = {6'h00, eqSkip_ff, 9'h000};
  wire [15:0] nxt_eq = mergeBytes(eqImage, wData_ff, wStrb_ff);
  wire [15:0] lockImage = {5'h00, lockNoise_ff, 10'h000};
  wire [15:0] nxt_lock = mergeBytes(lockImage, wData_ff, wStrb_ff);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      maskOne_ff <= `SDIRX_RST_MASK;
      maskTwo_ff <= `SDIRX_RST_MASK;
      rateAuto_ff <= `SDIRX_RST_RATE_AUTO; // [RULE8]
      rateMan_ff <= `SDIRX_RST_RATE_MAN;
      clkDelay_ff <= `SDIRX_RST_CLK_DELAY;
      padDrive_ff <= `SDIRX_RST_PAD_DRIVE;
      eqSkip_ff <= `SDIRX_RST_FLAG;
      lockNoise_ff <= `SDIRX_RST_FLAG;
      irqEnable_ff <= `SDIRX_RST_IRQ;
    end else if (doWrite) begin
      case (awIdx_ff)
        `SDIRX_IDX_MASK_ONE:
          maskOne_ff <= nxt_maskOne & `SDIRX_MASK_ONE_BITS; // [RULE1]
        `SDIRX_IDX_MASK_TWO:
          maskTwo_ff <= nxt_maskTwo & `SDIRX_MASK_TWO_BITS; // [RULE2]
        `SDIRX_IDX_RATE_SEL: begin
          rateAuto_ff <= nxt_rate[`SDIRX_RATE_AUTO_BIT]; // [RULE8]
          rateMan_ff <= nxt_rate[1:0];
        end
        `SDIRX_IDX_CLK_DELAY: begin
          if (wStrb_ff[0]) begin
            clkDelay_ff <= wImage[5:0]; // [RULE4] [RULE5]
          end
        end
        `SDIRX_IDX_PAD_DRIVE: begin
          if (wStrb_ff[0]) begin
            padDrive_ff <= wImage[5:0];
          end
        end
        `SDIRX_IDX_EQ_SKIP:
          eqSkip_ff <= nxt_eq[`SDIRX_EQ_SKIP_BIT];
        `SDIRX_IDX_LOCK_NOISE:
          lockNoise_ff <= nxt_lock[`SDIRX_LOCK_NOISE_BIT]; // [RULE6]
        `SDIRX_IDX_IRQ_ENABLE: begin
          if (wStrb_ff[0]) begin
            irqEnable_ff <= wImage[2:0];
          end
        end
        default: begin
          // Ancillary bank and other indexes leave these registers unchanged
          irqEnable_ff <= irqEnable_ff; // [RULE9]
        end
      endcase
    end
  end

  assign ddrClockPhaseSelect = clkDelay_ff[`SDIRX_CLK_PHASE_BIT]; // [RULE4]
  assign delayTapOffset = clkDelay_ff[`SDIRX_DELAY_MSB:0]; // [RULE5]
  assign padDriveDataUpper = padDrive_ff[`SDIRX_PAD_MSB_HI:4];
  assign padDriveStatus = padDrive_ff[`SDIRX_PAD_STAT_HI:2];
  assign padDriveDataLower = padDrive_ff[`SDIRX_PAD_LSB_HI:0];
  assign equalizerSkip = eqSkip_ff;
  // Passed through unqualified; software keeps it to automatic rate
  assign lockNoiseImmunityEnable = lockNoise_ff; // [RULE6]
  assign rateDetectAutomatic = rateAuto_ff; // [RULE8]
  assign manualRateSelect = rateMan_ff;

  ////////////////////////////////////////////////////////////////////////
  // Global error vector, registered to keep outputs glitch free
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      globalErrorStreamOne <= 11'h000;
      globalErrorStreamTwo <= 7'h00;
    end else begin
      globalErrorStreamOne <= faultsStreamOne &
        ~maskOne_ff[10:0] & 11'h77F; // [RULE3] [RULE1]
      globalErrorStreamTwo <= faultsStreamTwo &
        ~maskTwo_ff[6:0]; // [RULE3] [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, a set beats a clear in the same cycle
  wire [2:0] irqEvents = {ancWrEn, |globalErrorStreamTwo,
    |globalErrorStreamOne};
  wire irqClearHit = doWrite && (awIdx_ff == `SDIRX_IDX_IRQ_CLEAR) &&
    wStrb_ff[0];
  wire [2:0] irqClearBits = irqClearHit ? wImage[2:0] : 3'h0;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus_ff <= `SDIRX_RST_IRQ;
    end else begin
      irqStatus_ff <= (irqStatus_ff & ~irqClearBits) | irqEvents;
    end
  end

  assign irq = |(irqStatus_ff & irqEnable_ff);

  ////////////////////////////////////////////////////////////////////////
  // Ancillary memory, filled only by the extraction engine
  always @(posedge clk) begin
    if (ancWrEn) begin
      ancMem[ancWrAddr] <= {ancWrUpperWord, ancWrLowerWord}; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel, one cycle after address acceptance
  assign s_axi_arready = !s_axi_rvalid;

  wire [13:0] arIdx = s_axi_araddr[15:2];
  reg [15:0] rdImage;

  always @* begin
    rdImage = 16'h0000;
    case (arIdx)
      `SDIRX_IDX_MASK_ONE: rdImage = maskOne_ff;
      `SDIRX_IDX_MASK_TWO: rdImage = maskTwo_ff;
      `SDIRX_IDX_RATE_SEL: rdImage = rateImage;
      `SDIRX_IDX_CLK_DELAY: rdImage = {10'h000, clkDelay_ff};
      `SDIRX_IDX_PAD_DRIVE: rdImage = {10'h000, padDrive_ff};
      `SDIRX_IDX_EQ_SKIP: rdImage = eqImage;
      `SDIRX_IDX_LOCK_NOISE: rdImage = lockImage;
      `SDIRX_IDX_IRQ_STATUS: rdImage = {13'h0000, irqStatus_ff};
      `SDIRX_IDX_IRQ_ENABLE: rdImage = {13'h0000, irqEnable_ff};
      default: rdImage = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SDIRX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(arIdx) ? `SDIRX_RESP_OKAY :
        `SDIRX_RESP_SLVERR;
      if (inAncBank(arIdx)) begin
        s_axi_rdata <= {16'h0000, ancMem[arIdx[9:0]]}; // [RULE9] [RULE10]
      end else begin
        s_axi_rdata <= {16'h0000, rdImage};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sdirx_regs
